// ==== hw/irqsl_params.svh ====
`ifndef IRQSL_PARAMS_SVH
`define IRQSL_PARAMS_SVH

// ----------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------
`define IRQSL_LAT_ERR_ADDR 32'h0001_AA08
`define IRQSL_LAT_FORCE_ADDR 32'h0001_AA0C
`define IRQSL_LAT_CTRL_ADDR 32'h0001_AA10
`define IRQSL_GLOB_STATUS_ADDR 32'h0001_AC00
`define IRQSL_GLOB_ENABLE_ADDR 32'h0001_AC04

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define IRQSL_PORT_LSB 16
`define IRQSL_NUM_PORTS 16
`define IRQSL_BIT_RESET_SYM 4
`define IRQSL_BIT_MC_EVENT_SYM 5
`define IRQSL_BIT_SERIAL_MGMT 6
`define IRQSL_BIT_FABRIC_ERR 7
`define IRQSL_BIT_MC_LATENCY 14
`define IRQSL_BIT_AUTO_ISOLATE 0

// ----------------------------------------------------------------
// Reset values and writable masks
// ----------------------------------------------------------------
`define IRQSL_RESET_WORD 32'h0000_0000
`define IRQSL_ENABLE_MASK 32'hFFFF_40F0
`define IRQSL_PORT_MASK 32'hFFFF_0000
`define IRQSL_CTRL_MASK 32'h0000_0001

`endif

// ==== hw/irqsl_pkg.sv ====
package irqsl_pkg;

    // Broadcast buffer activity as seen by the purge logic
    typedef struct packed {
        logic wr_active;
        logic tx_active;
    } irqsl_buf_status_t;

    // Commands back to one broadcast buffer
    typedef struct packed {
        logic flush;
        logic drop_wr;
    } irqsl_buf_cmd_t;

    typedef enum logic {
        PG_IDLE,
        PG_WAIT_TX
    } irqsl_purge_state_t;

endpackage : irqsl_pkg

// ==== hw/irqsl_port_purge.sv ====
`timescale 1ns/1ps

module irqsl_port_purge
    import irqsl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Override event and buffer activity
    input wire logic force_evt,
    input irqsl_buf_status_t status,
    // Buffer commands
    output irqsl_buf_cmd_t cmd
);

    irqsl_purge_state_t state;
    irqsl_purge_state_t next_state;
    logic next_flush;
    logic next_drop_wr;

    // ----------------------------------------------------------------
    // Purge sequencing
    // ----------------------------------------------------------------
    // outgoing packet kept: flush waits until transmission ends
    assign next_flush = (state == PG_IDLE) ? (force_evt && !status.tx_active)
                                           : !status.tx_active;
    // incoming packet dropped until its write finishes
    assign next_drop_wr = status.wr_active && (force_evt || cmd.drop_wr);

    always_comb begin
        next_state = state;
        case (state)
            PG_IDLE: begin
                if (force_evt && status.tx_active) begin
                    next_state = PG_WAIT_TX;
                end
            end
            PG_WAIT_TX: begin
                if (!status.tx_active) begin
                    next_state = PG_IDLE;
                end
            end
            default: begin
                next_state = PG_IDLE;
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= PG_IDLE;
            cmd <= '0;
        end else begin
            state <= next_state;
            cmd.flush <= next_flush;
            cmd.drop_wr <= next_drop_wr;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence idle_force_s;
        force_evt && !status.tx_active && state == PG_IDLE;
    endsequence

    flush_follows_force_a: assert property (
        @(posedge pclk) disable iff (!presetn) idle_force_s |=> cmd.flush)
        else $error("flush missing after override");

    flush_spares_tx_a: assert property (
        @(posedge pclk) disable iff (!presetn) cmd.flush |-> !$past(status.tx_active))
        else $error("flush issued during transmission");

    drop_during_write_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        force_evt && status.wr_active |=> cmd.drop_wr)
        else $error("incoming packet not dropped");

endmodule : irqsl_port_purge

// ==== hw/irqsl_top.sv ====
// Behaviour
// - Writing 1 to a port override bit sets that port's latency error bit.
// - A forced error flushes all stored data of that port's broadcast buffer.
// - A packet being written into that buffer at the time is discarded too.
// - The packet being sent out of the buffer completes and is kept.
// - With auto isolation on, forced-error ports receive no multicast.
// - Override bit 16 is port 15 down to bit 31 port 0; bits 0-15 read zero.
// - Each 1 written to bits 16-31 makes one override event; 0 does nothing; bits reset 0.
// - Each global status bit is the OR of its source block's requests.
// - Status bit 4 is the OR of reset control symbol interrupts of all ports.
// - Status bit 5 is the OR of multicast-event symbol interrupts of all ports.
// - Status bit 7 flags a fabric transfer error.
// - Status bit 14 is high while any buffer's latency error is set.
// - Status bits 0-3 read zero; the whole status word is read-only.
// - Latency error bits clear on writing 1; with auto isolation on, set bits exclude multicast.
// - Any set latency error bit raises the multicast latency status bit.
// - A request drives the active-low interrupt only when its enable is set.
`timescale 1ns/1ps
`include "irqsl_params.svh"

module irqsl_top
    import irqsl_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Interrupt sources, index is port number
    input wire logic [15:0] port_irq,
    input wire logic [15:0] reset_symbol_irq,
    input wire logic [15:0] multicast_event_symbol_irq,
    input wire logic [15:0] fabric_transfer_error_irq,
    input wire logic serial_mgmt_irq,
    input wire logic [15:0] latency_expired,
    // Broadcast buffers, index is port number
    input irqsl_buf_status_t [15:0] buf_status,
    output irqsl_buf_cmd_t [15:0] buf_cmd,
    output logic [15:0] mc_deliver_en,
    // Interrupt pin
    output logic irq_n
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Port p lives at word bit 31 - p
    function automatic logic [31:0] irqsl_place_ports(input logic [15:0] v);
        logic [31:0] w;
        w = 32'h0000_0000;
        for (int p = 0; p < 16; p++) begin
            w[31 - p] = v[p];
        end
        return w;
    endfunction : irqsl_place_ports

    function automatic logic [15:0] irqsl_pick_ports(input logic [31:0] w);
        logic [15:0] v;
        v = 16'h0000;
        for (int p = 0; p < 16; p++) begin
            v[p] = w[31 - p];
        end
        return v;
    endfunction : irqsl_pick_ports

    // ----------------------------------------------------------------
    // State
    // ----------------------------------------------------------------
    logic [15:0] lat_err;
    logic [31:0] glob_enable;
    logic [31:0] glob_status;
    logic auto_isolate_on_latency;

    logic [15:0] next_lat_err;
    logic [31:0] next_glob_status;
    logic [31:0] next_prdata;
    logic [15:0] force_evt;
    logic [15:0] lat_clr;
    logic next_auto_isolate;

    // ----------------------------------------------------------------
    // APB decode
    // ----------------------------------------------------------------
    wire access = psel && penable && !pready;
    wire wr_en = psel && penable && pready && pwrite;
    wire hit_err = (paddr == `IRQSL_LAT_ERR_ADDR);
    wire hit_force = (paddr == `IRQSL_LAT_FORCE_ADDR);
    wire hit_ctrl = (paddr == `IRQSL_LAT_CTRL_ADDR);
    wire hit_status = (paddr == `IRQSL_GLOB_STATUS_ADDR);
    wire hit_enable = (paddr == `IRQSL_GLOB_ENABLE_ADDR);
    wire hit_any = hit_err || hit_force || hit_ctrl || hit_status || hit_enable;

    // Override bits read back as zero: they only ever produce events
    assign next_prdata = !hit_any || pwrite ? `IRQSL_RESET_WORD :
                         hit_err ? irqsl_place_ports(lat_err) :
                         hit_ctrl ? {31'h0000_0000, auto_isolate_on_latency} :
                         hit_status ? glob_status :
                         hit_enable ? glob_enable :
                         `IRQSL_RESET_WORD;

    assign force_evt = (wr_en && hit_force) ? irqsl_pick_ports(pwdata) : 16'h0000;
    assign lat_clr = (wr_en && hit_err) ? irqsl_pick_ports(pwdata) : 16'h0000;
    // Isolation follows a control write at once, so an errored port never leaks a cycle
    assign next_auto_isolate = (wr_en && hit_ctrl) ? pwdata[`IRQSL_BIT_AUTO_ISOLATE]
                                                   : auto_isolate_on_latency;

    // Every access takes exactly three cycles: pready rises on the third
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= `IRQSL_RESET_WORD;
        end else begin
            pready <= access;
            pslverr <= access && !hit_any;
            prdata <= access ? next_prdata : `IRQSL_RESET_WORD;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            glob_enable <= `IRQSL_RESET_WORD;
            auto_isolate_on_latency <= 1'b0;
        end else if (wr_en && hit_enable) begin
            glob_enable <= pwdata & `IRQSL_ENABLE_MASK;
        end else if (wr_en && hit_ctrl) begin
            auto_isolate_on_latency <= pwdata[`IRQSL_BIT_AUTO_ISOLATE];
        end
    end

    // ----------------------------------------------------------------
    // Latency error bits
    // ----------------------------------------------------------------
    // override sets error; a set always beats a clear
    assign next_lat_err = (lat_err & ~lat_clr) | latency_expired | force_evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_err <= 16'h0000;
        end else begin
            lat_err <= next_lat_err;
        end
    end

    // ----------------------------------------------------------------
    // Broadcast buffer purge, one sequencer per port
    // ----------------------------------------------------------------
    generate
        for (genvar p = 0; p < 16; p++) begin : g_purge
            irqsl_port_purge u_purge (
                .pclk(pclk),
                .presetn(presetn),
                .force_evt(force_evt[p]),
                .status(buf_status[p]),
                .cmd(buf_cmd[p])
            );
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mc_deliver_en <= 16'hFFFF;
        end else begin
            mc_deliver_en <= next_auto_isolate ? ~next_lat_err : 16'hFFFF;
        end
    end

    // ----------------------------------------------------------------
    // Global status and interrupt pin
    // ----------------------------------------------------------------
    // each bit ORs its source
    always_comb begin
        next_glob_status = irqsl_place_ports(port_irq);
        next_glob_status[`IRQSL_BIT_RESET_SYM] = |reset_symbol_irq;
        next_glob_status[`IRQSL_BIT_MC_EVENT_SYM] = |multicast_event_symbol_irq;
        next_glob_status[`IRQSL_BIT_SERIAL_MGMT] = serial_mgmt_irq;
        next_glob_status[`IRQSL_BIT_FABRIC_ERR] = |fabric_transfer_error_irq;
        next_glob_status[`IRQSL_BIT_MC_LATENCY] = |next_lat_err;
    end

    // port summaries placed by port order
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            glob_status <= `IRQSL_RESET_WORD;
            irq_n <= 1'b1;
        end else begin
            glob_status <= next_glob_status;
            irq_n <= ~|(glob_status & glob_enable);
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    sequence force_write_s;
        psel && penable && pready && pwrite && hit_force && pwdata[31];
    endsequence

    sequence clear_only_s;
        psel && penable && pready && pwrite && hit_err && pwdata[31]
            && !latency_expired[0];
    endsequence

    force_sets_err_a: assert property (
        @(posedge pclk) disable iff (!presetn) force_write_s |=> lat_err[0])
        else $error("override did not set port 0 error");

    zero_no_event_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && hit_force && !pwdata[16] |-> !force_evt[15])
        else $error("written zero raised an override");

    force_reads_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        access && hit_force |=> prdata == `IRQSL_RESET_WORD)
        else $error("override register read nonzero");

    err_clear_a: assert property (
        @(posedge pclk) disable iff (!presetn) clear_only_s |=> !lat_err[0])
        else $error("latency error did not clear");

    isolate_port_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        auto_isolate_on_latency && lat_err[3] |-> !mc_deliver_en[3])
        else $error("errored port still receives multicast");

    latency_summary_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 glob_status[`IRQSL_BIT_MC_LATENCY] == (|lat_err))
        else $error("latency summary mismatch");

    reserved_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        glob_status[3:0] == 4'h0 && glob_status[13:8] == 6'h00 && !glob_status[15])
        else $error("reserved status bit set");

    reset_sym_or_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        |reset_symbol_irq |=> glob_status[`IRQSL_BIT_RESET_SYM])
        else $error("reset symbol summary missing");

    port_order_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        port_irq[15] && !port_irq[0] |=> glob_status[16] && !glob_status[31])
        else $error("port summary placed wrongly");

    irq_pin_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        glob_status[14] && glob_enable[14] |=> !irq_n)
        else $error("enabled request did not drive pin");

    irq_masked_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        glob_enable == `IRQSL_RESET_WORD [*2] |-> irq_n)
        else $error("pin driven with all enables clear");

    rst_sym_idle_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 glob_status[`IRQSL_BIT_RESET_SYM] == $past(|reset_symbol_irq))
        else $error("reset symbol summary wrong");

    mc_event_or_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 glob_status[`IRQSL_BIT_MC_EVENT_SYM] == $past(|multicast_event_symbol_irq))
        else $error("multicast event summary wrong");

    fabric_err_or_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 glob_status[`IRQSL_BIT_FABRIC_ERR] == $past(|fabric_transfer_error_irq))
        else $error("fabric error summary wrong");

    serial_mgmt_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 glob_status[`IRQSL_BIT_SERIAL_MGMT] == $past(serial_mgmt_irq))
        else $error("serial management bit wrong");

    port_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        ##1 glob_status[31] == $past(port_irq[0]))
        else $error("port 0 summary wrong");

    reserved_force_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        wr_en && hit_force && pwdata[31:16] == 16'h0000 |-> force_evt == 16'h0000)
        else $error("reserved override bit raised an event");

    one_event_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        |force_evt |=> force_evt == 16'h0000)
        else $error("override event longer than one cycle");

    err_hold_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        lat_err[0] && !lat_clr[0] |=> lat_err[0])
        else $error("latency error lost without a clear");

    expire_sets_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        |latency_expired |=> glob_status[`IRQSL_BIT_MC_LATENCY])
        else $error("expiry did not raise latency summary");

    deliver_restore_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !next_auto_isolate |=> mc_deliver_en == 16'hFFFF)
        else $error("port isolated with auto isolation off");

    force_isolates_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        force_evt[0] && next_auto_isolate |=> !mc_deliver_en[0])
        else $error("forced port still receives multicast");

    irq_release_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (glob_status & glob_enable) == `IRQSL_RESET_WORD |=> irq_n)
        else $error("pin driven with no enabled request");

    enable_reserved_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (glob_enable & ~`IRQSL_ENABLE_MASK) == `IRQSL_RESET_WORD)
        else $error("reserved enable bit set");

endmodule : irqsl_top

// ==== verif/irq_status_latency_override_tb.sv ====
`timescale 1ns/1ps
`include "irqsl_params.svh"

module irq_status_latency_override_tb
    import irqsl_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic serial_mgmt_irq, irq_n, err;
    logic [31:0] paddr, pwdata, prdata, rd;
    logic [15:0] port_irq, reset_symbol_irq, multicast_event_symbol_irq;
    logic [15:0] fabric_transfer_error_irq, latency_expired, mc_deliver_en;
    irqsl_buf_status_t [15:0] buf_status;
    irqsl_buf_cmd_t [15:0] buf_cmd;
    int n_fail, comparisons;

    irqsl_top u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_irq(port_irq),
        .reset_symbol_irq(reset_symbol_irq),
        .multicast_event_symbol_irq(multicast_event_symbol_irq),
        .fabric_transfer_error_irq(fabric_transfer_error_irq),
        .serial_mgmt_irq(serial_mgmt_irq), .latency_expired(latency_expired),
        .buf_status(buf_status), .buf_cmd(buf_cmd),
        .mc_deliver_en(mc_deliver_en), .irq_n(irq_n)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task end_sim;
        $display("comparisons %0d n_fail %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_sim

    task check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("CHECK FAILED at %0t got %h expected %h", $time, got, exp);
        end
    endtask : check

    // Holds the request until pready is sampled high at a rising edge
    task apb(input logic wr, input logic [31:0] addr, input logic [31:0] data);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= addr;
        pwdata <= data;
        @(posedge pclk);
        penable <= 1'b1;
        i = 0;
        do begin
            @(posedge pclk);
            i++;
        end while (pready !== 1'b1 && i < 20);
        if (pready !== 1'b1) begin
            n_fail++;
            end_sim();
        end else begin
            rd = prdata;
            err = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    task rd_chk(input logic [31:0] addr, input logic [31:0] exp);
        apb(1'b0, addr, 32'h0000_0000);
        check(rd, exp);
    endtask : rd_chk

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_reset;
        check(mc_deliver_en, 32'h0000_FFFF);
        check(buf_cmd, 32'h0000_0000);
        check(irq_n, 32'h0000_0001);
        rd_chk(`IRQSL_LAT_FORCE_ADDR, 32'h0000_0000);
        rd_chk(`IRQSL_GLOB_STATUS_ADDR, 32'h0000_0000);
    endtask : t_reset

    // Sources are live levels, so one at a time isolates each bit
    task t_status;
        reset_symbol_irq <= 16'h0080;
        rd_chk(`IRQSL_GLOB_STATUS_ADDR, 32'h0000_0010);
        reset_symbol_irq <= 16'h0000;
        multicast_event_symbol_irq <= 16'h8000;
        rd_chk(`IRQSL_GLOB_STATUS_ADDR, 32'h0000_0020);
        multicast_event_symbol_irq <= 16'h0000;
        serial_mgmt_irq <= 1'b1;
        rd_chk(`IRQSL_GLOB_STATUS_ADDR, 32'h0000_0040);
        serial_mgmt_irq <= 1'b0;
        fabric_transfer_error_irq <= 16'h0001;
        rd_chk(`IRQSL_GLOB_STATUS_ADDR, 32'h0000_0080);
        fabric_transfer_error_irq <= 16'h0000;
        port_irq <= 16'h8000;
        rd_chk(`IRQSL_GLOB_STATUS_ADDR, 32'h0001_0000);
        port_irq <= 16'h8001;
        rd_chk(`IRQSL_GLOB_STATUS_ADDR, 32'h8001_0000);
        apb(1'b1, `IRQSL_GLOB_STATUS_ADDR, 32'hFFFF_FFFF);
        rd_chk(`IRQSL_GLOB_STATUS_ADDR, 32'h8001_0000);
        port_irq <= 16'h0000;
    endtask : t_status

    task t_force;
        apb(1'b1, `IRQSL_LAT_CTRL_ADDR, 32'h0000_0001);
        apb(1'b1, `IRQSL_LAT_FORCE_ADDR, 32'h0000_FFFF);
        rd_chk(`IRQSL_LAT_ERR_ADDR, 32'h0000_0000);
        apb(1'b1, `IRQSL_LAT_FORCE_ADDR, 32'h8000_0000);
        #1;
        check(buf_cmd[0], 32'h0000_0002);
        check(mc_deliver_en, 32'h0000_FFFE);
        @(posedge pclk);
        #1;
        check(buf_cmd[0], 32'h0000_0000);
        rd_chk(`IRQSL_LAT_ERR_ADDR, 32'h8000_0000);
        rd_chk(`IRQSL_GLOB_STATUS_ADDR, 32'h0000_4000);
    endtask : t_force

    // Outgoing packet must finish before the flush; incoming one is dropped
    task t_purge;
        buf_status[15] <= 2'b11;
        apb(1'b1, `IRQSL_LAT_FORCE_ADDR, 32'h0001_0000);
        #1;
        check(buf_cmd[15], 32'h0000_0001);
        repeat (3) @(posedge pclk);
        #1;
        check(buf_cmd[15], 32'h0000_0001);
        @(posedge pclk);
        buf_status[15].tx_active <= 1'b0;
        @(posedge pclk);
        #1;
        check(buf_cmd[15], 32'h0000_0003);
        @(posedge pclk);
        buf_status[15].wr_active <= 1'b0;
        repeat (2) @(posedge pclk);
        #1;
        check(buf_cmd[15], 32'h0000_0000);
        check(mc_deliver_en, 32'h0000_7FFE);
        @(posedge pclk);
        latency_expired <= 16'h0008;
        @(posedge pclk);
        latency_expired <= 16'h0000;
        rd_chk(`IRQSL_LAT_ERR_ADDR, 32'h9001_0000);
        // Errors stay set while isolation is switched off and on again
        apb(1'b1, `IRQSL_LAT_CTRL_ADDR, 32'h0000_0000);
        @(posedge pclk);
        check(mc_deliver_en, 32'h0000_FFFF);
        apb(1'b1, `IRQSL_LAT_CTRL_ADDR, 32'h0000_0001);
        @(posedge pclk);
        check(mc_deliver_en, 32'h0000_7FF6);
    endtask : t_purge

    task t_irq;
        check(irq_n, 32'h0000_0001);
        apb(1'b1, `IRQSL_GLOB_ENABLE_ADDR, 32'hFFFF_FFFF);
        rd_chk(`IRQSL_GLOB_ENABLE_ADDR, 32'hFFFF_40F0);
        check(irq_n, 32'h0000_0000);
        apb(1'b1, `IRQSL_GLOB_ENABLE_ADDR, 32'h0000_00F0);
        rd_chk(`IRQSL_GLOB_ENABLE_ADDR, 32'h0000_00F0);
        check(irq_n, 32'h0000_0001);
        apb(1'b1, `IRQSL_GLOB_ENABLE_ADDR, 32'h0000_4000);
        // The pin follows the enable one cycle after the status word
        repeat (2) @(posedge pclk);
        check(irq_n, 32'h0000_0000);
        apb(1'b1, `IRQSL_LAT_ERR_ADDR, 32'hFFFF_FFFF);
        rd_chk(`IRQSL_LAT_ERR_ADDR, 32'h0000_0000);
        check(mc_deliver_en, 32'h0000_FFFF);
        rd_chk(`IRQSL_GLOB_STATUS_ADDR, 32'h0000_0000);
        check(irq_n, 32'h0000_0001);
        apb(1'b0, 32'h0001_AA00, 32'h0000_0000);
        check(err, 32'h0000_0001);
        check(rd, 32'h0000_0000);
    endtask : t_irq

    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        n_fail = 0;
        comparisons = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0000_0000;
        pwdata = 32'h0000_0000;
        port_irq = 16'h0000;
        reset_symbol_irq = 16'h0000;
        multicast_event_symbol_irq = 16'h0000;
        fabric_transfer_error_irq = 16'h0000;
        serial_mgmt_irq = 1'b0;
        latency_expired = 16'h0000;
        buf_status = '0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_status();
        t_force();
        t_purge();
        t_irq();
        end_sim();
    end
endmodule : irq_status_latency_override_tb
